//--- bdt_edge_sync.v
// Two-stage synchroniser with edge detection for the burst clock pin
`timescale 1ns/1ps
module bdt_edge_sync (
   input wire clk_i,
   input wire rst_i,
   input wire gate_i,
   input wire pin_i,
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta_q;
   reg sync_q;
   reg last_q;

   // First stage read only by the second; gate holds all stages low
   always @(posedge clk_i) begin
      if (rst_i || !gate_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o = sync_q & ~last_q;
   assign fall_o = ~sync_q & last_q;
endmodule // bdt_edge_sync

//--- bdt_host_model.sv
// Host model: burst clock, read strobes and flash plane data feed
`timescale 1ns/1ps
module bdt_host_model (
   input wire clk_i,
   input wire plane_fetch_i,
   input wire [15:0] data_i,
   output logic burst_clk_o,
   output logic cs_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [31:0] plane_o
);
   logic [15:0] pc;
   logic [15:0] w [0:15];
   initial begin
      burst_clk_o = 1'b0;
      cs_n_o = 1'b1;
      oe_n_o = 1'b1;
      we_n_o = 1'b1;
   end
   // Pair index restarts per select so every burst begins at pair zero
   always @(posedge clk_i) begin
      if (cs_n_o) pc <= 16'h0000;
      else if (plane_fetch_i) pc <= pc + 16'h0001;
   end
   assign plane_o = {16'h4001 + {pc[14:0], 1'b0}, 16'h4000 + {pc[14:0], 1'b0}};
   // Clock stands low outside frames; words taken late in the high phase
   task automatic burst(input logic inv, input logic [2:0] lat, input logic hold,
                        input int len, input logic wr);
      int first;
      int k;
      first = lat + 2 + inv;
      k = 0;
      cs_n_o = 1'b0;
      we_n_o = !wr;
      oe_n_o = wr;
      #300;
      for (int r = 0; r < first + len * (hold + 1); r++) begin
         burst_clk_o = 1'b1;
         #100;
         if (r >= first && (r - first) % (hold + 1) == 0) begin
            w[k] = data_i;
            k++;
         end
         burst_clk_o = 1'b0;
         #100;
      end
      cs_n_o = 1'b1;
      oe_n_o = 1'b1;
      we_n_o = 1'b1;
      #300;
   endtask
   // One sector is 256 word reads of 512 bytes per request
   task automatic reads(input int n);
      repeat (n) begin
         cs_n_o = 1'b0;
         oe_n_o = 1'b0;
         #100;
         cs_n_o = 1'b1;
         oe_n_o = 1'b1;
         #100;
      end
   endtask
endmodule // bdt_host_model

//--- bdt_port.v
// Burst read, DMA request and fast output control for the flash disk host port
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "bdt_regs.vh"
module bdt_port #(
   parameter LEN_W = 8,
   parameter CNT_W = 7
) (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg wb_ack_o,
   output wire wb_err_o,
   input wire burst_clk_i,
   input wire chip_select_n_i,
   input wire output_enable_n_i,
   input wire write_enable_n_i,
   input wire reset_input_n_i,
   input wire [31:0] plane_data_i,
   output reg plane_fetch_o,
   input wire ecc_error_i,
   output reg [15:0] data_o,
   output wire data_oe_n_o,
   output wire transfer_request_n_o,
   output wire interrupt_request_n_o
);
   // Burst, DMA, output control and status registers
   reg burst_en_q, inv_q, hold_q, dma_en_q, pulse_q, fast_q, done_q, err_q;
   reg [2:0] lat_q;
   reg [LEN_W-1:0] len_q;
   reg [CNT_W-1:0] cnt_q;
   wire wb_req, wb_wr;
   reg dma_start, sector_end;

   // Synchronised pins
   reg cs_m_q, cs_s_q, oe_m_q, oe_s_q, we_m_q, we_s_q, rn_m_q, rn_s_q;
   wire rst_pin_n;
   wire clk_rise;
   wire clk_fall;

   always @(posedge clk_i) begin
      if (rst_i) begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         oe_m_q <= 1'b1;
         oe_s_q <= 1'b1;
         we_m_q <= 1'b1;
         we_s_q <= 1'b1;
         rn_m_q <= 1'b0;
         rn_s_q <= 1'b0;
      end else begin
         cs_m_q <= chip_select_n_i;
         cs_s_q <= cs_m_q;
         oe_m_q <= output_enable_n_i;
         oe_s_q <= oe_m_q;
         we_m_q <= write_enable_n_i;
         we_s_q <= we_m_q;
         rn_m_q <= reset_input_n_i;
         rn_s_q <= rn_m_q;
      end
   end
   assign rst_pin_n = rn_s_q;

   // Clock pin gated off unless enabled and the reset pin is released
   bdt_edge_sync u_clk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .gate_i(burst_en_q & rst_pin_n),
      .pin_i(burst_clk_i),
      .level_o(),
      .rise_o(clk_rise),
      .fall_o(clk_fall)
   );

   // Wishbone decode: single-cycle ack, unmapped reads give zero
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_req & wb_we_i;
   assign wb_err_o = 1'b0;

   function [31:0] bdt_rd;
      input [3:0] adr;
      begin
         bdt_rd = 32'h0000_0000;
         case (adr)
            `BDT_ADR_BURST: begin
               bdt_rd[`BDT_B_EN] = burst_en_q;
               bdt_rd[`BDT_B_INV] = inv_q;
               bdt_rd[`BDT_B_LAT_HI:`BDT_B_LAT_LO] = lat_q;
               bdt_rd[`BDT_B_HOLD] = hold_q;
               bdt_rd[`BDT_B_LEN_HI:`BDT_B_LEN_LO] = len_q;
            end
            `BDT_ADR_DMA: begin
               bdt_rd[`BDT_D_EN] = dma_en_q;
               bdt_rd[`BDT_D_PULSE] = pulse_q;
               bdt_rd[`BDT_D_CNT_HI:`BDT_D_CNT_LO] = cnt_q[5:0];
            end
            `BDT_ADR_OUTCTL: bdt_rd[`BDT_O_FAST] = fast_q;
            `BDT_ADR_STATUS: begin
               bdt_rd[`BDT_S_DONE] = done_q;
               bdt_rd[`BDT_S_ERR] = err_q;
               bdt_rd[`BDT_S_ACTIVE] = dma_en_q;
               bdt_rd[`BDT_S_BURST] = burst_en_q;
            end
            default: bdt_rd = 32'h0000_0000;
         endcase
      end
   endfunction

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? bdt_rd(wb_adr_i) : 32'h0000_0000;
      end
   end

   // Configuration writes; reset pin also clears burst enable
   always @(posedge clk_i) begin
      if (rst_i) begin
         burst_en_q <= 1'b0;
         inv_q <= 1'b0;
         lat_q <= 3'h0;
         hold_q <= 1'b0;
         len_q <= {LEN_W{1'b0}};
         fast_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         if (!rst_pin_n) begin
            burst_en_q <= 1'b0;
         end else if (wb_wr && wb_adr_i == `BDT_ADR_BURST && wb_sel_i[0]) begin
            burst_en_q <= wb_dat_i[`BDT_B_EN];
            inv_q <= wb_dat_i[`BDT_B_INV];
            lat_q <= wb_dat_i[`BDT_B_LAT_HI:`BDT_B_LAT_LO];
            hold_q <= wb_dat_i[`BDT_B_HOLD];
         end
         if (wb_wr && wb_adr_i == `BDT_ADR_BURST && wb_sel_i[1]) begin
            len_q <= wb_dat_i[`BDT_B_LEN_HI:`BDT_B_LEN_LO];
         end
         if (wb_wr && wb_adr_i == `BDT_ADR_OUTCTL && wb_sel_i[0]) begin
            fast_q <= wb_dat_i[`BDT_O_FAST];
         end
         if (wb_wr && wb_adr_i == `BDT_ADR_DMA && wb_sel_i[0]) begin
            pulse_q <= wb_dat_i[`BDT_D_PULSE];
         end
      end
   end

   // Burst engine: sample select on chosen clock edge, present words on rising
   localparam B_IDLE = 2'h0;
   localparam B_WAIT = 2'h1;
   localparam B_DATA = 2'h2;
   localparam B_DONE = 2'h3;
   reg [1:0] bst_q;
   reg [3:0] wait_q;
   reg [LEN_W-1:0] left_q;
   reg half_q;
   reg hold_ph_q;
   reg [15:0] upper_q;
   wire sel_rd;
   wire samp;

   assign sel_rd = ~cs_s_q & ~oe_s_q & we_s_q;
   assign samp = inv_q ? clk_fall : clk_rise;

   always @(posedge clk_i) begin
      if (rst_i || !burst_en_q) begin
         bst_q <= B_IDLE;
         wait_q <= 4'h0;
         left_q <= {LEN_W{1'b0}};
         half_q <= 1'b0;
         hold_ph_q <= 1'b0;
         upper_q <= 16'h0000;
         data_o <= 16'h0000;
         plane_fetch_o <= 1'b0;
      end else begin
         plane_fetch_o <= 1'b0;
         case (bst_q)
            B_IDLE: begin
               if (samp && sel_rd) begin
                  // Falling sample: next rising edge is the half cycle
                  wait_q <= {1'b0, lat_q} + `BDT_BASE_LAT - {3'h0, ~inv_q};
                  left_q <= len_q;
                  half_q <= 1'b0;
                  hold_ph_q <= 1'b0;
                  bst_q <= B_WAIT;
               end
            end
            B_WAIT: begin
               if (!sel_rd) begin
                  bst_q <= B_IDLE;
               end else if (clk_rise) begin
                  if (wait_q == 4'h0) begin
                     data_o <= plane_data_i[15:0];
                     upper_q <= plane_data_i[31:16];
                     half_q <= 1'b1;
                     plane_fetch_o <= 1'b1;
                     left_q <= left_q - {{(LEN_W-1){1'b0}}, 1'b1};
                     bst_q <= B_DATA;
                  end else begin
                     wait_q <= wait_q - 4'h1;
                  end
               end
            end
            B_DATA: begin
               if (!sel_rd) begin
                  bst_q <= B_IDLE;
               end else if (clk_rise) begin
                  if (hold_q && !hold_ph_q) begin
                     hold_ph_q <= 1'b1;
                  end else if (left_q == {LEN_W{1'b0}}) begin
                     bst_q <= B_DONE;
                  end else begin
                     hold_ph_q <= 1'b0;
                     left_q <= left_q - {{(LEN_W-1){1'b0}}, 1'b1};
                     if (half_q) begin
                        data_o <= upper_q;
                        half_q <= 1'b0;
                     end else begin
                        data_o <= plane_data_i[15:0];
                        upper_q <= plane_data_i[31:16];
                        half_q <= 1'b1;
                        plane_fetch_o <= 1'b1;
                     end
                  end
               end
            end
            B_DONE: begin
               if (!sel_rd) begin
                  bst_q <= B_IDLE;
               end
            end
            default: bst_q <= B_IDLE;
         endcase
      end
   end

   // Output buffers: fast mode at select, else only while words are presented
   assign data_oe_n_o = ~(sel_rd & (fast_q | bst_q == B_DATA));

   // DMA sequencer: counts flash words read, one sector at a time
   localparam D_IDLE = 2'h0;
   localparam D_XFER = 2'h1;
   localparam D_HALT = 2'h2;
   localparam [31:0] PULSE_CYC = `BDT_PULSE_CYC; // Only the low bits fit the timer
   reg [1:0] dst_q;
   reg [8:0] word_q;
   reg [CNT_W-1:0] rem_q;
   reg req_lvl_q;
   reg [3:0] pulse_cnt_q;
   reg rd_q;
   wire rd_end;
   wire raise_req, pulse_mode;

   assign rd_end = rd_q & ~sel_rd;

   always @* begin
      dma_start = wb_wr && wb_adr_i == `BDT_ADR_DMA && wb_sel_i[0]
         && wb_dat_i[`BDT_D_EN];
      sector_end = dst_q == D_XFER && rd_end && word_q == `BDT_SECT_WORDS - 9'h1;
   end

   assign raise_req = dma_start | (sector_end & ~ecc_error_i & dma_en_q);
   assign pulse_mode = dma_start ? wb_dat_i[`BDT_D_PULSE] : pulse_q; // Start write sets style

   always @(posedge clk_i) begin
      if (rst_i) begin
         dst_q <= D_IDLE;
         word_q <= 9'h000;
         rem_q <= {CNT_W{1'b0}};
         cnt_q <= {CNT_W{1'b0}};
         dma_en_q <= 1'b0;
         req_lvl_q <= 1'b0;
         pulse_cnt_q <= 4'h0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         rd_q <= sel_rd;
         // Pulse timer runs independently of the state
         if (raise_req && pulse_mode) begin
            pulse_cnt_q <= PULSE_CYC[3:0];
         end else if (pulse_cnt_q != 4'h0) begin
            pulse_cnt_q <= pulse_cnt_q - 4'h1;
         end
         // Done and error status bits cleared by writing one; a new event wins
         if (wb_wr && wb_adr_i == `BDT_ADR_STATUS) begin
            if (wb_dat_i[`BDT_S_DONE]) done_q <= 1'b0;
            if (wb_dat_i[`BDT_S_ERR]) err_q <= 1'b0;
         end
         if (wb_wr && wb_adr_i == `BDT_ADR_DMA && wb_sel_i[0]) begin
            cnt_q <= wb_dat_i[`BDT_D_CNT_HI:`BDT_D_CNT_LO] == 6'h00 ? `BDT_MAX_SECT
               : {1'b0, wb_dat_i[`BDT_D_CNT_HI:`BDT_D_CNT_LO]};
            dma_en_q <= wb_dat_i[`BDT_D_EN];
         end
         case (dst_q)
            D_IDLE, D_HALT: begin
               if (dma_start) begin
                  rem_q <= wb_dat_i[`BDT_D_CNT_HI:`BDT_D_CNT_LO] == 6'h00 ? `BDT_MAX_SECT
                     : {1'b0, wb_dat_i[`BDT_D_CNT_HI:`BDT_D_CNT_LO]};
                  word_q <= 9'h000;
                  req_lvl_q <= 1'b1;
                  dst_q <= D_XFER;
               end
            end
            D_XFER: begin
               if (rd_end) begin
                  word_q <= word_q + 9'h001;
               end
               if (sector_end) begin
                  word_q <= 9'h000;
                  req_lvl_q <= 1'b0;
                  if (ecc_error_i) begin
                     err_q <= 1'b1;
                     dma_en_q <= 1'b0;
                     dst_q <= D_HALT;
                  end else if (rem_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                     done_q <= 1'b1;
                     rem_q <= {CNT_W{1'b0}};
                     dma_en_q <= 1'b0;
                     dst_q <= D_IDLE;
                  end else if (!dma_en_q) begin
                     dst_q <= D_IDLE;
                  end else begin
                     rem_q <= rem_q - {{(CNT_W-1){1'b0}}, 1'b1};
                     req_lvl_q <= 1'b1;
                  end
               end
            end
            default: dst_q <= D_IDLE;
         endcase
      end
   end

   // Request and interrupt pins, both active low
   assign transfer_request_n_o = pulse_q ? (pulse_cnt_q == 4'h0)
      : ~req_lvl_q;
   assign interrupt_request_n_o = ~(done_q | err_q);
endmodule // bdt_port

//--- bdt_port_props.sv
// Pin-level concurrent checks for the burst/DMA read port
`timescale 1ns/1ps
`include "bdt_regs.vh"
module bdt_port_props #(
   parameter LEN_W = 8,
   parameter CNT_W = 7
) (
   input wire clk_i,
   input wire rst_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire wb_err_o,
   input wire burst_clk_i,
   input wire chip_select_n_i,
   input wire output_enable_n_i,
   input wire write_enable_n_i,
   input wire reset_input_n_i,
   input wire [31:0] plane_data_i,
   input wire plane_fetch_o,
   input wire ecc_error_i,
   input wire [15:0] data_o,
   input wire data_oe_n_o,
   input wire transfer_request_n_o,
   input wire interrupt_request_n_o
);
   logic pul_q, fast_q, wr_tk;
   logic [3:0] sel_q, oe_q, wr_q, pin_q;
   assign wr_tk = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   // Mode shadows load on the taken edge, in step with the slave
   always @(posedge clk_i) begin
      if (rst_i) begin
         pul_q <= 1'b0;
         fast_q <= 1'b0;
      end else if (wr_tk && wb_adr_i == `BDT_ADR_DMA) begin
         pul_q <= wb_dat_i[`BDT_D_PULSE];
      end else if (wr_tk && wb_adr_i == `BDT_ADR_OUTCTL) begin
         fast_q <= wb_dat_i[`BDT_O_FAST];
      end
   end
   // Four-sample pin histories; longer than the two-stage sync delay
   always @(posedge clk_i) begin
      sel_q <= {sel_q[2:0], !chip_select_n_i && !output_enable_n_i};
      oe_q <= {oe_q[2:0], output_enable_n_i};
      wr_q <= {wr_q[2:0], !write_enable_n_i};
      pin_q <= {pin_q[2:0], !reset_input_n_i};
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   AST_ERR_LOW: assert property (!wb_err_o)
      else $error("bus error raised");
   AST_RST_IDLE: assert property ($past(rst_i) |-> transfer_request_n_o && interrupt_request_n_o)
      else $error("request or interrupt active out of reset");
   AST_DMA_REQ: assert property (
      wb_ack_o && wb_we_i && wb_adr_i == `BDT_ADR_DMA && wb_sel_i[0] && wb_dat_i[`BDT_D_EN]
      |-> ##[0:2] !transfer_request_n_o) else $error("no request after dma enable");
   AST_PULSE_WIDTH: assert property (
      pul_q && $fell(transfer_request_n_o)
      |-> !transfer_request_n_o [*8] ##1 !transfer_request_n_o [*2]
      ##[1:11] transfer_request_n_o)
      else $error("request pulse outside 250 to 500 ns");
   AST_LEVEL_HOLD: assert property (
      !pul_q && $fell(transfer_request_n_o) |-> !transfer_request_n_o [*8])
      else $error("level request dropped early");
   AST_FAST_OE: assert property (fast_q && (&sel_q) |-> !data_oe_n_o)
      else $error("fast mode buffers not enabled");
   AST_OE_IDLE: assert property ((&oe_q) |-> data_oe_n_o)
      else $error("data driven without output enable");
   AST_NO_FETCH: assert property ((&wr_q || &pin_q) |-> !plane_fetch_o)
      else $error("plane fetch during write or pin reset");
endmodule // bdt_port_props

bind bdt_port bdt_port_props #(.LEN_W(LEN_W), .CNT_W(CNT_W)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .burst_clk_i(burst_clk_i),
   .chip_select_n_i(chip_select_n_i), .output_enable_n_i(output_enable_n_i),
   .write_enable_n_i(write_enable_n_i), .reset_input_n_i(reset_input_n_i),
   .plane_data_i(plane_data_i), .plane_fetch_o(plane_fetch_o), .ecc_error_i(ecc_error_i),
   .data_o(data_o), .data_oe_n_o(data_oe_n_o), .transfer_request_n_o(transfer_request_n_o),
   .interrupt_request_n_o(interrupt_request_n_o));

//--- bdt_regs.vh
// Register offsets, fields, sector sizes and timing constants for the burst/DMA read port
`ifndef BDT_REGS_VH
`define BDT_REGS_VH
// Word addresses on the Wishbone slave
`define BDT_ADR_BURST    4'h0
`define BDT_ADR_DMA      4'h1
`define BDT_ADR_OUTCTL   4'h2
`define BDT_ADR_STATUS   4'h3
`define BDT_ADR_NOP      4'h4
`define BDT_ADR_FLASH    4'h5
// Burst control fields
`define BDT_B_EN         0
`define BDT_B_INV        1
`define BDT_B_LAT_LO     2
`define BDT_B_LAT_HI     4
`define BDT_B_HOLD       5
`define BDT_B_LEN_LO     8
`define BDT_B_LEN_HI     15
// DMA control fields
`define BDT_D_EN         0
`define BDT_D_PULSE      1
`define BDT_D_CNT_LO     8
`define BDT_D_CNT_HI     13
// Output control fields
`define BDT_O_FAST       0
// Status fields
`define BDT_S_DONE       0
`define BDT_S_ERR        1
`define BDT_S_ACTIVE     2
`define BDT_S_BURST      3
// Sector size in 16-bit words, and largest sector count (64 x 512 B = 32 KB)
`define BDT_SECT_WORDS   9'h100
`define BDT_MAX_SECT     7'h40
// Pulse request time, ns; 40 MHz clock
`define BDT_PULSE_NS     300
`define BDT_CLK_MHZ      40
`define BDT_PULSE_CYC    ((`BDT_PULSE_NS * `BDT_CLK_MHZ + 999) / 1000)
`define BDT_BASE_LAT     4'h2
`endif

//--- testbench.sv
// Self-checking bench for the burst/DMA read port
`timescale 1ns/1ps
`include "bdt_regs.vh"
module testbench;
   logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, reset_input_n_i;
   logic burst_clk_i, chip_select_n_i, output_enable_n_i, write_enable_n_i, s;
   logic plane_fetch_o, ecc_error_i, data_oe_n_o, transfer_request_n_o, interrupt_request_n_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, plane_data_i, q, cfg;
   logic [15:0] data_o, pre;
   int n_errors = 0;
   int checks = 0;
   bdt_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .burst_clk_i(burst_clk_i), .chip_select_n_i(chip_select_n_i),
      .output_enable_n_i(output_enable_n_i), .write_enable_n_i(write_enable_n_i),
      .reset_input_n_i(reset_input_n_i), .plane_data_i(plane_data_i),
      .plane_fetch_o(plane_fetch_o), .ecc_error_i(ecc_error_i), .data_o(data_o),
      .data_oe_n_o(data_oe_n_o), .transfer_request_n_o(transfer_request_n_o),
      .interrupt_request_n_o(interrupt_request_n_o));
   bdt_host_model u_host (.clk_i(clk_i), .plane_fetch_i(plane_fetch_o), .data_i(data_o),
      .burst_clk_o(burst_clk_i), .cs_n_o(chip_select_n_i), .oe_n_o(output_enable_n_i),
      .we_n_o(write_enable_n_i), .plane_o(plane_data_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle; held until ack is sampled, released on that edge
   task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i <= we;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   // Watches the request or interrupt pin for a fixed window
   task automatic wait_low(input logic irq, input int lim, output logic seen);
      seen = 1'b0;
      repeat (lim) begin
         @(negedge clk_i);
         if ((irq ? interrupt_request_n_o : transfer_request_n_o) === 1'b0) seen = 1'b1;
      end
   endtask
   task automatic stop_test;
      $display("Checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_i = 1'b1;
      wb_we_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      reset_input_n_i = 1'b1;
      ecc_error_i = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset pin synchroniser leaves reset asserted; let it fill first
      repeat (2) @(posedge clk_i);
      // Plain burst, then falling-edge sampling with longest delay and hold
      for (int t = 0; t < 2; t++) begin
         cfg = t ? 32'h0000033F : 32'h00000401;
         wb(`BDT_ADR_BURST, 1'b1, cfg, q);
         wb(`BDT_ADR_BURST, 1'b0, 32'h0, q);
         chk(q, cfg);
         u_host.burst(cfg[1], cfg[4:2], cfg[5], cfg[15:8], 1'b0);
         for (int i = 0; i < cfg[15:8]; i++) chk({16'h0, u_host.w[i]}, 32'h4000 + i);
      end
      u_host.burst(1'b0, 3'h0, 1'b0, 4, 1'b1);
      wb(`BDT_ADR_BURST, 1'b1, 32'h00000400, q);
      @(negedge clk_i);
      pre = data_o;
      u_host.burst(1'b0, 3'h0, 1'b0, 4, 1'b0);
      chk({16'h0, u_host.w[3]}, {16'h0, pre});
      wb(`BDT_ADR_BURST, 1'b1, 32'h00000401, q);
      reset_input_n_i <= 1'b0;
      u_host.burst(1'b0, 3'h0, 1'b0, 4, 1'b0);
      chk({16'h0, u_host.w[3]}, {16'h0, pre});
      @(posedge clk_i);
      reset_input_n_i <= 1'b1;
      // Fast output only once bursts are over
      wb(`BDT_ADR_OUTCTL, 1'b1, 32'h00000001, q);
      // Pulse mode, two sectors, clean data
      wb(`BDT_ADR_DMA, 1'b1, 32'h00000203, q);
      wait_low(1'b0, 40, s);
      chk({31'h0, s}, 32'h1);
      for (int i = 0; i < 2; i++) begin
         u_host.reads(256);
         wait_low(1'b0, 40, s);
         chk({31'h0, s}, 32'h1);
         chk({31'h0, interrupt_request_n_o}, {31'h0, i == 0});
      end
      wb(`BDT_ADR_STATUS, 1'b0, 32'h0, q);
      chk(q & 32'h3, 32'h1);
      wb(`BDT_ADR_STATUS, 1'b1, 32'h3, q);
      // Level mode, error at the first of two sectors halts the run
      ecc_error_i <= 1'b1;
      wb(`BDT_ADR_DMA, 1'b1, 32'h00000201, q);
      wait_low(1'b0, 5, s);
      chk({31'h0, s}, 32'h1);
      u_host.reads(256);
      wait_low(1'b0, 20, s);
      chk({31'h0, transfer_request_n_o, s}, 32'h2);
      chk({31'h0, interrupt_request_n_o}, 32'h0);
      wb(`BDT_ADR_STATUS, 1'b0, 32'h0, q);
      chk(q & 32'h3, 32'h2);
      ecc_error_i <= 1'b0;
      wb(`BDT_ADR_STATUS, 1'b1, 32'h3, q);
      // Abort during the first of three sectors
      wb(`BDT_ADR_DMA, 1'b1, 32'h00000303, q);
      wait_low(1'b0, 40, s);
      wb(`BDT_ADR_DMA, 1'b1, 32'h0, q);
      u_host.reads(256);
      wait_low(1'b0, 60, s);
      chk({31'h0, s}, 32'h0);
      // Interrupt exit from bursts: seven no-op writes, then bursts off
      repeat (7) wb(`BDT_ADR_NOP, 1'b1, 32'h0, q);
      wb(`BDT_ADR_BURST, 1'b1, 32'h0, q);
      wb(4'hF, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      stop_test;
   end
   // Watchdog, well past the few hundred microseconds the run needs
   initial begin
      #1000000;
      n_errors++;
      stop_test;
   end
endmodule // testbench
